/* File: core/dbro_channel.sv */
// Purpose: One DMA channel: bus tenure, ring areas, address update
// Assumes: Bus controller pulses beat_done per access-size transfer
// Notes: APB slave, zero wait states, registered read data
// Contract
// - Cycle stealing releases bus after each unit
// - Other channel request: release, let it run
// - Burst keeps bus until end, no preemption
// - Release bus next cycle; optional handover
// - Block mode is cycle stealing per block
// - Clearing run stops; accepted request still served
// - Size error, repeat end, overflow clear run
// - Independent source/destination ring areas wrap
// - Ring sizes from address control fields
// - Source overflow with enable: flag, halt
// - Flag with enable raises overflow interrupt
// - Same overflow stop for destination ring
// - Setting run again resumes after overflow
// - Block mode defers overflow until block end
// - Step mode moves by 1, 2 or 4
// - Fixed mode leaves address unchanged
// - Offset mode adds offset per transfer
// - Offset only added; negatives by software
// - Repeat end restores source, raises interrupt
// - Restart continues with rewritten source address
// - Only auto request may select burst
// - Update select: fixed, offset, inc, dec
// - Access size byte, word, longword steps
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module dbro_channel
    import dbro_pkg::*;
(
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped
    input wire logic external_request_n, // Request pin, active low
    input wire logic onchip_req, // Peripheral request pulse
    input wire logic other_chan_req, // Another channel wants service
    input wire logic bus_grant, // Bus granted to channel
    input wire logic beat_done, // One access-size transfer done
    input wire logic xfer_last, // Transfer end condition
    input wire logic size_err, // Transfer size error pulse
    input wire logic bus_release_between_channels, // Pass bus between masters
    output logic bus_req, // Channel wants the bus
    output logic bus_hold, // Channel holds the bus
    output logic bus_yield, // Pass bus to another master
    output logic [31:0] src_addr, // Current source address
    output logic [31:0] dst_addr, // Current destination address
    output logic ring_overflow_irq, // Overflow interrupt request
    output logic repeat_end_irq // Repeat end interrupt request
);
    dbro_state_t st_q, st_d;
    logic [31:0] mode_q, mode_d, actl_q, actl_d, src_q, src_d, dst_q, dst_d;
    logic [31:0] offs_q, offs_d, bsize_q, bsize_d, rd_q, rd_d, start_q, start_d;
    logic [15:0] bcnt_q, bcnt_d;
    logic pend_q, pend_d, dfr_q, dfr_d, ext_s1_q, ext_s2_q;
    logic wr, rd, mapped, burst, blk, req_in, unit_end, stop_hw;
    logic s_ovf, d_ovf, blk_end, start_blk;
    logic [31:0] s_nxt, d_nxt, step;

    // Request pin synchroniser
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
        end
        else
        begin
            ext_s1_q <= external_request_n;
            ext_s2_q <= ext_s1_q;
        end
    end

    // Step size per access size
    always_comb
    begin
        unique case (mode_q[MB_SIZE_LO +: 2])
            SZ_WORD: step = STEP_WORD;
            SZ_LONG: step = STEP_LONG;
            default: step = STEP_BYTE;
        endcase
    end

    // Next address with ring wrap; overflow when upper bits would change
    function automatic logic [31:0] upd_addr(input logic [31:0] a, input logic [1:0] sel,
        input logic [31:0] stp, input logic [31:0] ofs, input logic [4:0] ring);
        logic [31:0] raw;
        logic [31:0] msk;
        raw = a;
        msk = (32'h0000_0001 << ring) - 32'h0000_0001;
        unique case (sel)
            UPD_FIXED: raw = a;
            UPD_OFFSET: raw = a + ofs;
            UPD_INC: raw = a + stp;
            UPD_DEC: raw = a - stp;
        endcase
        if (ring != 5'h00)
            upd_addr = (a & ~msk) | (raw & msk);
        else
            upd_addr = raw;
    endfunction

    function automatic logic ring_wrap(input logic [31:0] a, input logic [1:0] sel,
        input logic [31:0] stp, input logic [31:0] ofs, input logic [4:0] ring);
        logic [31:0] raw;
        logic [31:0] msk;
        raw = upd_addr(a, sel, stp, ofs, 5'h00);
        msk = (32'h0000_0001 << ring) - 32'h0000_0001;
        ring_wrap = (ring != 5'h00) && (((raw ^ a) & ~msk) != 32'h0000_0000);
    endfunction

    // Decode, mode and events
    always_comb
    begin
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        mapped = (paddr <= OFS_BSIZE) && (paddr[1:0] == 2'b00);
        blk = mode_q[MB_BLOCK] || mode_q[MB_REPEAT];
        burst = mode_q[MB_BURST] && (mode_q[MB_SRC_LO +: 2] == ACT_AUTO)
            && !mode_q[MB_BLOCK];
        unique case (mode_q[MB_SRC_LO +: 2])
            ACT_AUTO: req_in = 1'b1;
            ACT_ONCHIP: req_in = onchip_req;
            ACT_EXT: req_in = !ext_s2_q;
            default: req_in = 1'b0;
        endcase
        s_nxt = upd_addr(src_q, actl_q[AB_SSEL_LO +: 2], step, offs_q,
            actl_q[AB_SRING_LO +: 5]);
        d_nxt = upd_addr(dst_q, actl_q[AB_DSEL_LO +: 2], step, offs_q,
            actl_q[AB_DRING_LO +: 5]);
        s_ovf = ring_wrap(src_q, actl_q[AB_SSEL_LO +: 2], step, offs_q,
            actl_q[AB_SRING_LO +: 5]) && actl_q[AB_SRING_IE];
        d_ovf = ring_wrap(dst_q, actl_q[AB_DSEL_LO +: 2], step, offs_q,
            actl_q[AB_DRING_LO +: 5]) && actl_q[AB_DRING_IE];
        start_blk = bcnt_q == 16'h0000;
        blk_end = blk && (bcnt_q == bsize_q[15:0] - 16'h0001
            || bsize_q[15:0] <= 16'h0001);
    end

    // Next state of channel, registers and bus read
    always_comb
    begin
        st_d = st_q;
        mode_d = mode_q;
        actl_d = actl_q;
        src_d = src_q;
        dst_d = dst_q;
        offs_d = offs_q;
        bsize_d = bsize_q;
        start_d = start_q;
        bcnt_d = bcnt_q;
        pend_d = pend_q;
        dfr_d = dfr_q;
        rd_d = rd_q;
        stop_hw = 1'b0;
        unit_end = 1'b0;
        // Latch a request only while the channel runs
        if (mode_q[MB_RUN] && req_in)
            pend_d = 1'b1;
        if (st_q == ST_BUS && beat_done)
        begin
            if (start_blk)
                start_d = src_q;
            src_d = s_nxt;
            dst_d = d_nxt;
            bcnt_d = bcnt_q + 16'h0001;
            // Block mode holds a ring overflow back until the block end
            if (mode_q[MB_BLOCK] && (s_ovf || d_ovf) && !blk_end)
                dfr_d = 1'b1;
            if (((s_ovf || d_ovf) && !(mode_q[MB_BLOCK] && !blk_end))
                || (blk_end && dfr_q))
            begin
                mode_d[MB_ROVF] = 1'b1;
                stop_hw = 1'b1;
            end
            if (blk_end)
            begin
                bcnt_d = 16'h0000;
                dfr_d = 1'b0;
                if (actl_q[AB_RPT_SRC])
                    src_d = start_blk ? src_q : start_q;
                if (mode_q[MB_REPEAT])
                begin
                    mode_d[MB_REND] = 1'b1;
                    stop_hw = 1'b1;
                end
            end
            unit_end = burst ? (xfer_last || !mode_q[MB_RUN]) :
                (!mode_q[MB_BLOCK] || blk_end);
            // End condition stops the channel and drops a request latched meanwhile
            if (xfer_last)
            begin
                mode_d[MB_RUN] = 1'b0;
                pend_d = 1'b0;
            end
        end
        if (size_err)
        begin
            mode_d[MB_SERR] = 1'b1;
            stop_hw = 1'b1;
        end
        if (stop_hw)
        begin
            mode_d[MB_RUN] = 1'b0;
            pend_d = 1'b0;
            unit_end = unit_end || st_q == ST_BUS;
        end
        // Bus tenure
        unique case (st_q)
            ST_IDLE:
                if (bus_grant && bus_req)
                begin
                    st_d = ST_BUS;
                    pend_d = 1'b0;
                end
            ST_BUS:
                if (unit_end)
                    st_d = ST_REL;
            ST_REL:
                st_d = ST_IDLE;
        endcase
        // Register writes; software write beats the hardware update except on the flag bits
        if (wr && mapped)
        begin
            unique case (paddr)
                OFS_MODE:
                begin
                    mode_d[MB_RUN] = pwdata[MB_RUN];
                    mode_d[MB_SIZE_LO - 1:MB_BURST] = pwdata[MB_SIZE_LO - 1:MB_BURST];
                    mode_d[MB_SIZE_LO +: 2] = pwdata[MB_SIZE_LO +: 2];
                    mode_d[MB_ROVF_IE] = pwdata[MB_ROVF_IE];
                    mode_d[MB_REND_IE] = pwdata[MB_REND_IE];
                    // Flags clear on 0; a same-cycle hardware set wins
                    if (!pwdata[MB_ROVF] && !(mode_d[MB_ROVF] && !mode_q[MB_ROVF]))
                        mode_d[MB_ROVF] = 1'b0;
                    if (!pwdata[MB_REND] && !(mode_d[MB_REND] && !mode_q[MB_REND]))
                        mode_d[MB_REND] = 1'b0;
                    if (!pwdata[MB_SERR] && !size_err)
                        mode_d[MB_SERR] = 1'b0;
                end
                OFS_ACTL: actl_d = pwdata & ACTL_WMASK;
                OFS_SRC: src_d = pwdata;
                OFS_DST: dst_d = pwdata;
                OFS_OFFS: offs_d = pwdata;
                OFS_BSIZE:
                begin
                    bsize_d = pwdata & BSIZE_WMASK;
                    bcnt_d = 16'h0000;
                end
                default: offs_d = offs_q;
            endcase
        end
        // Read data captured in the setup phase
        rd_d = 32'h0000_0000;
        if (rd)
        begin
            unique case (paddr)
                OFS_MODE: rd_d = mode_q;
                OFS_ACTL: rd_d = actl_q;
                OFS_SRC: rd_d = src_q;
                OFS_DST: rd_d = dst_q;
                OFS_OFFS: rd_d = offs_q;
                OFS_BSIZE: rd_d = bsize_q;
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= ST_IDLE;
            mode_q <= 32'h0000_0000;
            actl_q <= 32'h0000_0000;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            offs_q <= 32'h0000_0000;
            bsize_q <= 32'h0000_0000;
            start_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            bcnt_q <= 16'h0000;
            pend_q <= 1'b0;
            dfr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            mode_q <= mode_d;
            actl_q <= actl_d;
            src_q <= src_d;
            dst_q <= dst_d;
            offs_q <= offs_d;
            bsize_q <= bsize_d;
            start_q <= start_d;
            rd_q <= rd_d;
            bcnt_q <= bcnt_d;
            pend_q <= pend_d;
            dfr_q <= dfr_d;
        end
    end

    // Outputs
    assign prdata = rd_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign bus_req = st_q == ST_IDLE && (pend_q || (mode_q[MB_RUN] && req_in));
    assign bus_hold = st_q == ST_BUS;
    assign bus_yield = st_q == ST_REL && bus_release_between_channels;
    assign src_addr = src_q;
    assign dst_addr = dst_q;
    assign ring_overflow_irq = mode_q[MB_ROVF] && mode_q[MB_ROVF_IE];
    assign repeat_end_irq = mode_q[MB_REND] && mode_q[MB_REND_IE];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_beat;
        st_q == ST_BUS && beat_done && !(wr && mapped);
    endsequence

    a_steal_release: assert property (s_beat and !burst && !mode_q[MB_BLOCK]
        && !mode_q[MB_REPEAT] |=> st_q == ST_REL ##1 st_q == ST_IDLE)
        else $error("cycle steal did not release bus");
    a_burst_keep: assert property (s_beat and burst && !xfer_last && mode_q[MB_RUN]
        && !stop_hw && !size_err |=> bus_hold)
        else $error("burst released bus early");
    a_burst_end: assert property (s_beat and burst && xfer_last
        |=> !bus_hold && bus_yield == bus_release_between_channels)
        else $error("burst end did not release bus");
    a_fixed_addr: assert property (s_beat and actl_q[AB_SSEL_LO +: 2] == UPD_FIXED
        && !actl_q[AB_RPT_SRC] |=> src_q == $past(src_q))
        else $error("fixed source address moved");
    a_inc_step: assert property (s_beat and actl_q[AB_DSEL_LO +: 2] == UPD_INC
        && actl_q[AB_DRING_LO +: 5] == 5'h00 |=> dst_q == $past(dst_q) + $past(step))
        else $error("destination step wrong");
    a_offset_add: assert property (s_beat and actl_q[AB_DSEL_LO +: 2] == UPD_OFFSET
        && actl_q[AB_DRING_LO +: 5] == 5'h00 |=> dst_q == $past(dst_q) + offs_q)
        else $error("offset not added");
    a_ovf_halt: assert property (s_beat and s_ovf && !blk |=> mode_q[MB_ROVF]
        && !mode_q[MB_RUN] ##1 !bus_hold)
        else $error("source overflow did not halt");
    a_ovf_irq: assert property (s_beat and s_ovf && !blk && mode_q[MB_ROVF_IE]
        |=> ring_overflow_irq)
        else $error("overflow interrupt missing");
    a_serr_stop: assert property (size_err && !(wr && paddr == OFS_MODE)
        |=> !mode_q[MB_RUN] && mode_q[MB_SERR])
        else $error("size error left channel running");
    a_ring_upper: assert property (s_beat and actl_q[AB_SRING_LO +: 5] != 5'h00
        && !actl_q[AB_RPT_SRC] |=> ((src_q ^ $past(src_q)) >> $past(actl_q[AB_SRING_LO +: 5]))
        == 32'h0000_0000)
        else $error("ring area left");
    // Block tenure and request latch
    a_block_keep: assert property (s_beat and mode_q[MB_BLOCK] && !blk_end
        && !xfer_last && !size_err |=> bus_hold
        && mode_q[MB_ROVF] == $past(mode_q[MB_ROVF]))
        else $error("block tenure cut short or overflow not deferred");
    a_pend_keep: assert property (st_q == ST_IDLE && mode_q[MB_RUN] && req_in && !size_err
        |=> pend_q || bus_hold)
        else $error("accepted request lost");
endmodule // dbro_channel

/* File: core/dbro_pkg.sv */
// Purpose: Constants for the DMA channel bus-mode, ring and offset logic
// Assumes: APB byte addresses, 32-bit data
// Notes: Field positions refer to the register words below
package dbro_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ACTL = 8'h04;
    localparam logic [7:0] OFS_SRC = 8'h08;
    localparam logic [7:0] OFS_DST = 8'h0C;
    localparam logic [7:0] OFS_OFFS = 8'h10;
    localparam logic [7:0] OFS_BSIZE = 8'h14;
    // mode_control_reg fields
    localparam int MB_RUN = 0;
    localparam int MB_BURST = 1;
    localparam int MB_SRC_LO = 2;
    localparam int MB_BLOCK = 4;
    localparam int MB_REPEAT = 5;
    localparam int MB_SIZE_LO = 6;
    localparam int MB_ROVF = 8;
    localparam int MB_ROVF_IE = 9;
    localparam int MB_REND = 10;
    localparam int MB_REND_IE = 11;
    localparam int MB_SERR = 12;
    localparam logic [31:0] MODE_WMASK = 32'h0000_0EFF;
    // address_control_reg fields
    localparam int AB_SSEL_LO = 0;
    localparam int AB_DSEL_LO = 2;
    localparam int AB_SRING_LO = 4;
    localparam int AB_DRING_LO = 9;
    localparam int AB_SRING_IE = 14;
    localparam int AB_DRING_IE = 15;
    localparam int AB_RPT_SRC = 16;
    localparam logic [31:0] ACTL_WMASK = 32'h0001_FFFF;
    localparam logic [31:0] BSIZE_WMASK = 32'h0000_FFFF;
    // Address update selections
    localparam logic [1:0] UPD_FIXED = 2'h0;
    localparam logic [1:0] UPD_OFFSET = 2'h1;
    localparam logic [1:0] UPD_INC = 2'h2;
    localparam logic [1:0] UPD_DEC = 2'h3;
    // Access sizes and steps
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    // Activation sources
    localparam logic [1:0] ACT_AUTO = 2'h0;
    localparam logic [1:0] ACT_ONCHIP = 2'h1;
    localparam logic [1:0] ACT_EXT = 2'h2;
    // Channel states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUS = 3'b010,
        ST_REL = 3'b100
    } dbro_state_t;
endpackage

/* File: sim/dbro_busctl_model.sv */
// Purpose: Bus controller stand-in that grants the bus and paces beats
// Assumes: One beat every other cycle while the channel holds the bus
// Notes: Grant wait and end-of-transfer beat are set by the bench
`timescale 1ns/100ps
module dbro_busctl_model (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic bus_req, // Channel asks for the bus
    input wire logic bus_hold, // Channel owns the bus
    input wire logic [3:0] grant_wait, // Cycles before a grant
    input wire logic [7:0] end_at, // Beat that ends the transfer, 0 never
    output logic bus_grant, // Grant level
    output logic beat_done, // One access-size transfer done
    output logic xfer_last // End condition with a beat
);
    logic [3:0] wait_q;
    logic [7:0] cnt_q;

    // Slow or prompt grant, withdrawn once the request goes away
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 4'h0;
            bus_grant <= 1'b0;
            beat_done <= 1'b0;
            cnt_q <= 8'h00;
        end
        else
        begin
            if (bus_req && !bus_grant)
            begin
                bus_grant <= (wait_q >= grant_wait);
                wait_q <= wait_q + 4'h1;
            end
            else if (!bus_req)
            begin
                bus_grant <= 1'b0;
                wait_q <= 4'h0;
            end
            beat_done <= bus_hold && !beat_done;
            cnt_q <= (end_at == 8'h00) ? 8'h00 : cnt_q + 8'(beat_done);
        end
    end

    // Beats are counted across tenures so a block split can be seen
    assign xfer_last = beat_done && (end_at != 8'h00) && (cnt_q == end_at - 8'h01);
endmodule // dbro_busctl_model

/* File: sim/dma_bus_mode_ring_offset_tb_top.sv */
// Purpose: Self-checking bench for the DMA channel over APB
// Assumes: Zero-wait APB slave, partner model paces the bus
// Notes: External request pin and size error are pulsed by the tests
`timescale 1ns/100ps
module dma_bus_mode_ring_offset_tb_top
    import dbro_pkg::*;
;
    logic core_clk, nrst, psel, penable, pwrite, onchip_req, other_chan_req, brbc, serr, ext_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, src_addr, dst_addr, step;
    logic pready, pslverr, err, bus_grant, beat_done, xfer_last, bus_req, bus_hold;
    logic bus_yield, ring_overflow_irq, repeat_end_irq, hold_prev;
    logic [3:0] grant_wait;
    logic [7:0] end_at;
    int err_count, comparisons, yield_seen, tenures;

    dbro_channel dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_request_n(ext_n), .onchip_req(onchip_req),
        .other_chan_req(other_chan_req), .bus_grant(bus_grant), .beat_done(beat_done),
        .xfer_last(xfer_last), .size_err(serr), .bus_release_between_channels(brbc),
        .bus_req(bus_req), .bus_hold(bus_hold), .bus_yield(bus_yield), .src_addr(src_addr),
        .dst_addr(dst_addr), .ring_overflow_irq(ring_overflow_irq),
        .repeat_end_irq(repeat_end_irq));
    dbro_busctl_model bus_u (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
        .bus_hold(bus_hold), .grant_wait(grant_wait), .end_at(end_at),
        .bus_grant(bus_grant), .beat_done(beat_done), .xfer_last(xfer_last));

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Tenure and hand-over counts, sampled mid-cycle
    always @(negedge core_clk)
    begin
        yield_seen += int'(bus_yield === 1'b1);
        tenures += int'(bus_hold === 1'b1 && !hold_prev);
        hold_prev = (bus_hold === 1'b1);
    end

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; result lands in rd and err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        // Taken at the ready edge, before the request is released
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle request on both the on-chip line and the pin
    task automatic pulse;
        @(posedge core_clk);
        onchip_req <= 1'b1;
        ext_n <= 1'b0;
        @(posedge core_clk);
        onchip_req <= 1'b0;
        ext_n <= 1'b1;
    endtask

    // Wait for one tenure to start and end, bounded
    task automatic wait_hold;
        int n;
        n = 0;
        while (bus_hold !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        while (bus_hold === 1'b1 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (3) @(posedge core_clk);
    endtask

    task automatic unit;
        pulse();
        wait_hold();
    endtask

    function automatic logic [31:0] mode(input logic [1:0] sz, input logic [1:0] act,
        input logic [31:0] x);
        return 32'h0000_0001 | (32'(sz) << MB_SIZE_LO) | (32'(act) << MB_SRC_LO) | x;
    endfunction

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_sim();
    end

    initial
    begin
        {psel, penable, pwrite, onchip_req, other_chan_req, nrst} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        grant_wait = 4'h0;
        end_at = 8'h00;
        brbc = 1'b1;
        serr = 1'b0;
        ext_n = 1'b1;
        hold_prev = 1'b0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        apb(1'b0, OFS_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        // Step modes for every size; burst bit must not matter for on-chip or pin requests
        for (int s = 0; s < 3; s++)
        begin
            other_chan_req <= (s == 2);
            apb(1'b1, OFS_MODE, 32'h0000_0000);
            apb(1'b1, OFS_SRC, 32'h0000_1000);
            apb(1'b1, OFS_DST, 32'h0000_2000);
            apb(1'b1, OFS_ACTL, (32'(UPD_DEC) << AB_DSEL_LO) | 32'(UPD_INC));
            apb(1'b1, OFS_MODE, mode(s[1:0], (s == 1) ? ACT_EXT : ACT_ONCHIP, 32'h1 << MB_BURST));
            unit();
            step = (s == 0) ? STEP_BYTE : (s == 1) ? STEP_WORD : STEP_LONG;
            chk(src_addr, 32'h0000_1000 + step);
            chk(dst_addr, 32'h0000_2000 - step);
        end
        chk(32'(yield_seen > 0), 32'h0000_0001);
        // Negative offset on source wraps, fixed destination
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        apb(1'b1, OFS_OFFS, 32'hFFFF_FFF0);
        apb(1'b1, OFS_SRC, 32'h0000_0008);
        apb(1'b1, OFS_DST, 32'h0000_3000);
        apb(1'b1, OFS_ACTL, 32'(UPD_OFFSET));
        apb(1'b1, OFS_MODE, mode(SZ_LONG, ACT_ONCHIP, 32'h0));
        unit();
        unit();
        chk(src_addr, 32'hFFFF_FFE8);
        chk(dst_addr, 32'h0000_3000);
        // Burst keeps the bus through five beats despite another request
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        apb(1'b1, OFS_SRC, 32'h0000_0000);
        apb(1'b1, OFS_ACTL, 32'(UPD_INC));
        other_chan_req <= 1'b1;
        grant_wait <= 4'h3;
        end_at <= 8'h05;
        tenures = 0;
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_AUTO, 32'h1 << MB_BURST));
        wait_hold();
        chk(src_addr, 32'h0000_0005);
        chk(32'(tenures), 32'h0000_0001);
        apb(1'b0, OFS_MODE, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0000);
        // Block mode ignores burst: one tenure per three-byte block
        end_at <= 8'h00;
        apb(1'b1, OFS_SRC, 32'h0000_0000);
        apb(1'b1, OFS_BSIZE, 32'h0000_0003);
        end_at <= 8'h06;
        tenures = 0;
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_AUTO, (32'h1 << MB_BURST) | (32'h1 << MB_BLOCK)));
        wait_hold();
        wait_hold();
        chk(src_addr, 32'h0000_0006);
        chk(32'(tenures), 32'h0000_0002);
        end_at <= 8'h00;
        grant_wait <= 4'h0;
        // Source ring of 16 bytes overflows, stops, then resumes
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        apb(1'b1, OFS_SRC, 32'h0000_010E);
        apb(1'b1, OFS_ACTL, 32'(UPD_INC) | (32'h4 << AB_SRING_LO) | (32'h1 << AB_SRING_IE));
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_ONCHIP, 32'h1 << MB_ROVF_IE));
        unit();
        chk(src_addr, 32'h0000_010F);
        unit();
        chk(src_addr, 32'h0000_0100);
        chk(32'(ring_overflow_irq), 32'h0000_0001);
        apb(1'b0, OFS_MODE, 32'h0000_0000);
        chk(rd & 32'h0000_0101, 32'h0000_0100);
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_ONCHIP, 32'h1 << MB_ROVF_IE));
        unit();
        chk(src_addr, 32'h0000_0101);
        // Repeat area on source with offset: return, stop, restart from rewritten address
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        apb(1'b1, OFS_SRC, 32'h0000_0200);
        apb(1'b1, OFS_OFFS, 32'h0000_0010);
        apb(1'b1, OFS_BSIZE, 32'h0000_0002);
        apb(1'b1, OFS_ACTL, 32'(UPD_OFFSET) | (32'h1 << AB_RPT_SRC));
        apb(1'b1, OFS_MODE, mode(SZ_LONG, ACT_ONCHIP, (32'h1 << MB_REPEAT) | (32'h1 << MB_REND_IE)));
        unit();
        chk(src_addr, 32'h0000_0210);
        unit();
        chk(src_addr, 32'h0000_0200);
        chk(32'(repeat_end_irq), 32'h0000_0001);
        apb(1'b1, OFS_SRC, 32'h0000_0204);
        apb(1'b1, OFS_MODE, mode(SZ_LONG, ACT_ONCHIP, (32'h1 << MB_REPEAT) | (32'h1 << MB_REND_IE)));
        unit();
        chk(src_addr, 32'h0000_0214);
        // Request taken before run is cleared is still carried out
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        apb(1'b1, OFS_SRC, 32'h0000_0000);
        apb(1'b1, OFS_ACTL, 32'(UPD_INC));
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_ONCHIP, 32'h0));
        grant_wait <= 4'h8;
        pulse();
        apb(1'b1, OFS_MODE, 32'h0000_0000);
        wait_hold();
        chk(src_addr, 32'h0000_0001);
        // Block of four, a power of two, overruns the ring wrap and stops at its end
        apb(1'b1, OFS_SRC, 32'h0000_010E);
        apb(1'b1, OFS_BSIZE, 32'h0000_0004);
        apb(1'b1, OFS_ACTL, 32'(UPD_INC) | (32'h4 << AB_SRING_LO) | (32'h1 << AB_SRING_IE));
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_ONCHIP, (32'h1 << MB_BLOCK) | (32'h1 << MB_ROVF_IE)));
        unit();
        chk(src_addr, 32'h0000_0102);
        chk(32'(ring_overflow_irq), 32'h0000_0001);
        // Size error stops a running channel and sets its flag
        apb(1'b1, OFS_MODE, mode(SZ_BYTE, ACT_ONCHIP, 32'h0));
        @(posedge core_clk);
        serr <= 1'b1;
        @(posedge core_clk);
        serr <= 1'b0;
        apb(1'b0, OFS_MODE, 32'h0000_0000);
        chk(rd & 32'h0000_1001, 32'h0000_1000);
        end_sim();
    end
endmodule // dma_bus_mode_ring_offset_tb_top
